/* gpb_pkg.sv */
package gpb_pkg;
    // Bank shape
    localparam int PIN_COUNT = 8;
    localparam int SW_COUNT = 4;
    // Register index map (byte offsets on the plain register port)
    localparam logic [4:0] OFS_PIN_BASE = 5'h00;   // Pin controls 0x00..0x07
    localparam logic [4:0] OFS_SW_BASE = 5'h08;    // Switch controls 0x08..0x0b
    localparam logic [4:0] OFS_PIN_FLAGS = 5'h0c;  // Pin flags, write one to clear
    localparam logic [4:0] OFS_IRQ_STATUS = 5'h0d; // Summary status, write one to clear
    localparam logic [4:0] OFS_IRQ_MASK = 5'h0e;   // Summary mask
    // Field positions of a control register
    localparam int BIT_DRV = 0;
    localparam int BIT_DIR = 1;
    localparam int BIT_DIN = 2;
    localparam int BIT_DOUT = 3;
    localparam int BIT_EDGE_LO = 4;
    localparam int BIT_DBNC_LO = 6;
    localparam int BIT_SUMMARY_PIN = 4;            // Summary bit for pin events
    // Reset values: pins are inputs with output low, switches open drain low
    localparam logic [7:0] PIN_CTRL_RESET = 8'h02;
    localparam logic [7:0] SW_CTRL_RESET = 8'h00;
    localparam logic [7:0] SW_WRITE_MASK = 8'h39;  // Bits 1, 2, 6 and 7 reserved
    // Edge selector encodings
    localparam logic [1:0] EDGE_MASKED = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_RISE = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // Timing
    localparam int CLK_HZ = 25000000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int DBNC_STEP_MS = 10;
endpackage

/* gpb_ms_tick.sv */
`timescale 1ns/100ps
module gpb_ms_tick
    import gpb_pkg::*;
#(
    parameter int CYCLES = TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset_n,
    output logic tick
);
    // Wide enough for the default 25000 cycles
    logic [15:0] count_q;

    // Free running divider, one-cycle tick per wrap
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= 16'h0000;
            tick <= 1'b0;
        end else if (count_q == 16'(CYCLES - 1)) begin
            count_q <= 16'h0000;
            tick <= 1'b1;
        end else begin
            count_q <= count_q + 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule

/* gpb_debounce.sv */
`timescale 1ns/100ps
module gpb_debounce
    import gpb_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic msTick,
    input wire logic rawLevel,
    input wire logic [1:0] timeSel,
    output logic cleanLevel
);
    // Millisecond count of a stable differing level
    logic [5:0] stableMs_q;
    logic [5:0] target;

    // Required hold time in ms
    always_comb begin
        target = 6'(DBNC_STEP_MS * int'(timeSel));
    end

    // Accept a new level only after it held for the selected time
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            stableMs_q <= 6'h00;
            cleanLevel <= 1'b0;
        end else if (rawLevel == cleanLevel) begin
            stableMs_q <= 6'h00;                           // Bounce restarts the wait
        end else if (timeSel == 2'h0) begin
            cleanLevel <= rawLevel;                        // R13
        end else if (msTick) begin
            if (stableMs_q + 6'h01 >= target) begin        // R7 R13 R15
                cleanLevel <= rawLevel;
                stableMs_q <= 6'h00;
            end else begin
                stableMs_q <= stableMs_q + 6'h01;
            end
        end
    end
endmodule

/* gpb_pin_bank.sv */
`timescale 1ns/100ps
// What this block does
// R1: One 8-bit control register per module
// R2: Eight pin and four switch registers
// R3: Bit 0 picks open-drain or push-pull
// R4: Bit 1 direction; input ignores bit 0
// R5: Bit 2 reads pin level at read
// R6: Output mode input bit may be stale
// R7: Filter input transitions over milliseconds
// R8: Bit 3 is driven output level
// R9: Output level kept, applied on output mode
// R10: Edge select 00 masks the pin
// R11: 1 falling, 2 rising, 3 both edges
// R12: Pin edge also sets summary bit 4
// R13: Bits 7:6 pick 0/10/20/30 ms debounce
// R14: Flag register, bit n is pin n
// R15: Edges seen on debounced level, ms tick
module gpb_pin_bank
    import gpb_pkg::*;
#(
    parameter int PINS = PIN_COUNT,
    parameter int SWS = SW_COUNT,
    parameter int TICK_LEN = TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [4:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    input wire logic [PINS-1:0] pinIn,
    output logic [PINS-1:0] pinOut,
    output logic [PINS-1:0] pinOe_n,
    output logic [SWS-1:0] swOut,
    output logic [SWS-1:0] swOe_n,
    output logic irq
);
    // Control registers
    logic [7:0] pinCtrl_q [PINS];
    logic [7:0] swCtrl_q [SWS];
    // Sticky flags and summary interrupt
    logic [PINS-1:0] pinFlags_q;
    logic [7:0] irqStatus_q;
    logic [7:0] irqMask_q;
    // Filtered levels and their previous value
    logic [PINS-1:0] cleanLevel;
    logic [PINS-1:0] cleanPrev_q;
    logic [PINS-1:0] edgeHit;
    logic msTick;
    logic [7:0] rdData_d;

    // Shared millisecond timebase
    gpb_ms_tick #(
        .CYCLES(TICK_LEN)
    ) u_tick (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .tick(msTick)
    );

    // Per-pin register, filter, edge detect and driver
    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++) begin : g_pin
            gpb_debounce u_dbnc (
                .core_clk(core_clk),
                .reset_n(reset_n),
                .msTick(msTick),
                .rawLevel(pinIn[gi]),
                .timeSel(pinCtrl_q[gi][BIT_DBNC_LO +: 2]),
                .cleanLevel(cleanLevel[gi])
            );

            // Selector 0 passes a new level on the next edge
            property p_nodbnc;
                @(posedge core_clk) disable iff (!reset_n)
                (pinCtrl_q[gi][BIT_DBNC_LO +: 2] == 2'h0 && pinIn[gi] != cleanLevel[gi])
                |=> cleanLevel[gi] == $past(pinIn[gi]);
            endproperty
            a_nodbnc: assert property (p_nodbnc) // R13
                else $error("undebounced input lagged");

            // Software write; bit 2 is the live sample and not stored
            always_ff @(posedge core_clk or negedge reset_n) begin
                if (!reset_n) begin
                    pinCtrl_q[gi] <= PIN_CTRL_RESET;
                end else if (regWrite && regAddr == OFS_PIN_BASE + 5'(gi)) begin
                    pinCtrl_q[gi] <= regWrData & ~(8'h01 << BIT_DIN); // R1 R9
                end
            end

            // A write lands whole except the live level bit
            property p_ctrl_write;
                @(posedge core_clk) disable iff (!reset_n)
                (regWrite && regAddr == OFS_PIN_BASE + 5'(gi))
                |=> pinCtrl_q[gi] == ($past(regWrData) & 8'hfb);
            endproperty
            a_ctrl_write: assert property (p_ctrl_write) // R1 R9
                else $error("control write lost");

            // Read returns the pad level of the strobe cycle
            property p_read_level;
                @(posedge core_clk) disable iff (!reset_n)
                (regRead && regAddr == OFS_PIN_BASE + 5'(gi))
                |=> regRdData[BIT_DIN] == $past(pinIn[gi]);
            endproperty
            a_read_level: assert property (p_read_level) // R5
                else $error("sampled level wrong");

            // Edge detection on the filtered level
            always_comb begin
                unique case (pinCtrl_q[gi][BIT_EDGE_LO +: 2])
                    EDGE_FALL: edgeHit[gi] = cleanPrev_q[gi] & ~cleanLevel[gi]; // R11 R15
                    EDGE_RISE: edgeHit[gi] = ~cleanPrev_q[gi] & cleanLevel[gi]; // R11
                    EDGE_BOTH: edgeHit[gi] = cleanPrev_q[gi] ^ cleanLevel[gi]; // R11
                    EDGE_MASKED: edgeHit[gi] = 1'b0; // R10
                endcase
            end

            // Masked selector never raises the flag
            property p_mask_no_flag;
                @(posedge core_clk) disable iff (!reset_n)
                (pinCtrl_q[gi][BIT_EDGE_LO +: 2] == EDGE_MASKED && !pinFlags_q[gi])
                |=> !pinFlags_q[gi];
            endproperty
            a_mask_no_flag: assert property (p_mask_no_flag) // R10
                else $error("masked pin raised its flag");

            // Rising selector flags a clean rise
            property p_rise_flag;
                @(posedge core_clk) disable iff (!reset_n)
                (pinCtrl_q[gi][BIT_EDGE_LO +: 2] == EDGE_RISE && $rose(cleanLevel[gi]))
                |=> pinFlags_q[gi];
            endproperty
            a_rise_flag: assert property (p_rise_flag) // R11
                else $error("rising edge not flagged");

            // Falling selector flags a clean fall
            property p_fall_flag;
                @(posedge core_clk) disable iff (!reset_n)
                (pinCtrl_q[gi][BIT_EDGE_LO +: 2] == EDGE_FALL && $fell(cleanLevel[gi]))
                |=> pinFlags_q[gi];
            endproperty
            a_fall_flag: assert property (p_fall_flag) // R11
                else $error("falling edge not flagged");

            // Both-edge selector flags any clean change
            property p_both_flag;
                @(posedge core_clk) disable iff (!reset_n)
                (pinCtrl_q[gi][BIT_EDGE_LO +: 2] == EDGE_BOTH && $changed(cleanLevel[gi]))
                |=> pinFlags_q[gi];
            endproperty
            a_both_flag: assert property (p_both_flag) // R11 R15
                else $error("level change not flagged");

            // Pad drive: input mode releases, open drain never drives high
            always_ff @(posedge core_clk or negedge reset_n) begin
                if (!reset_n) begin
                    pinOut[gi] <= 1'b0;
                    pinOe_n[gi] <= 1'b1;
                end else if (pinCtrl_q[gi][BIT_DIR]) begin
                    pinOut[gi] <= 1'b0;
                    pinOe_n[gi] <= 1'b1;                  // R4 R9
                end else begin
                    pinOut[gi] <= pinCtrl_q[gi][BIT_DOUT]; // R8
                    pinOe_n[gi] <= ~(pinCtrl_q[gi][BIT_DRV] | ~pinCtrl_q[gi][BIT_DOUT]); // R3 R8
                end
            end

            // Input mode releases the pad
            property p_input_release;
                @(posedge core_clk) disable iff (!reset_n)
                pinCtrl_q[gi][BIT_DIR]
                |=> pinOe_n[gi];
            endproperty
            a_input_release: assert property (p_input_release) // R4
                else $error("input pin driven");

            // Open drain high only releases
            property p_od_high;
                @(posedge core_clk) disable iff (!reset_n)
                (!pinCtrl_q[gi][BIT_DIR] && !pinCtrl_q[gi][BIT_DRV] && pinCtrl_q[gi][BIT_DOUT])
                |=> pinOe_n[gi];
            endproperty
            a_od_high: assert property (p_od_high) // R3
                else $error("open drain drove high");

            // Output low always drives low
            property p_drive_low;
                @(posedge core_clk) disable iff (!reset_n)
                (!pinCtrl_q[gi][BIT_DIR] && !pinCtrl_q[gi][BIT_DOUT])
                |=> (!pinOe_n[gi] && !pinOut[gi]);
            endproperty
            a_drive_low: assert property (p_drive_low) // R8
                else $error("output low not driven");

            // Push-pull high drives high
            property p_cmos_high;
                @(posedge core_clk) disable iff (!reset_n)
                (!pinCtrl_q[gi][BIT_DIR] && pinCtrl_q[gi][BIT_DRV] && pinCtrl_q[gi][BIT_DOUT])
                |=> (!pinOe_n[gi] && pinOut[gi]);
            endproperty
            a_cmos_high: assert property (p_cmos_high) // R3 R8
                else $error("push-pull high not driven");
        end

        // Switch-gating outputs share the same driver scheme
        for (gi = 0; gi < SWS; gi++) begin : g_sw
            always_ff @(posedge core_clk or negedge reset_n) begin
                if (!reset_n) begin
                    swCtrl_q[gi] <= SW_CTRL_RESET;
                end else if (regWrite && regAddr == OFS_SW_BASE + 5'(gi)) begin
                    swCtrl_q[gi] <= regWrData & SW_WRITE_MASK; // R1 R2
                end
            end

            // Open drain low after reset
            always_ff @(posedge core_clk or negedge reset_n) begin
                if (!reset_n) begin
                    swOut[gi] <= 1'b0;
                    swOe_n[gi] <= 1'b0;
                end else begin
                    swOut[gi] <= swCtrl_q[gi][BIT_DOUT];
                    swOe_n[gi] <= ~(swCtrl_q[gi][BIT_DRV] | ~swCtrl_q[gi][BIT_DOUT]); // R3
                end
            end

            // Switch drives push-pull or pulls low as set
            property p_sw_drive;
                @(posedge core_clk) disable iff (!reset_n)
                (swCtrl_q[gi][BIT_DRV] || !swCtrl_q[gi][BIT_DOUT])
                |=> (!swOe_n[gi] && swOut[gi] == $past(swCtrl_q[gi][BIT_DOUT]));
            endproperty
            a_sw_drive: assert property (p_sw_drive) // R3
                else $error("switch output not driven");
        end
    endgenerate

    // Previous filtered level
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cleanPrev_q <= '0;
        end else begin
            cleanPrev_q <= cleanLevel;
        end
    end

    // Pin flags: set wins over write-one-to-clear
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pinFlags_q <= '0;
        end else begin
            if (regWrite && regAddr == OFS_PIN_FLAGS) begin
                pinFlags_q <= (pinFlags_q & ~regWrData[PINS-1:0]) | edgeHit; // R14
            end else begin
                pinFlags_q <= pinFlags_q | edgeHit; // R14
            end
        end
    end

    // Flags hold until software clears them
    property p_flag_sticky;
        @(posedge core_clk) disable iff (!reset_n)
        !(regWrite && regAddr == OFS_PIN_FLAGS)
        |=> (pinFlags_q & $past(pinFlags_q)) == $past(pinFlags_q);
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) // R14
        else $error("pin flag dropped");

    // Writing ones clears quiet flags
    property p_flag_clear;
        @(posedge core_clk) disable iff (!reset_n)
        (regWrite && regAddr == OFS_PIN_FLAGS && edgeHit == '0)
        |=> (pinFlags_q & $past(regWrData[PINS-1:0])) == '0;
    endproperty
    a_flag_clear: assert property (p_flag_clear) // R14
        else $error("pin flag not cleared");

    // Summary status; only the pin bit has a source here
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irqStatus_q <= 8'h00;
        end else begin
            if (regWrite && regAddr == OFS_IRQ_STATUS) begin
                irqStatus_q <= irqStatus_q & ~regWrData;
            end
            if (|edgeHit) begin
                irqStatus_q[BIT_SUMMARY_PIN] <= 1'b1; // R12
            end
        end
    end

    // Any flagged edge lifts the summary bit
    property p_summary;
        @(posedge core_clk) disable iff (!reset_n)
        (|edgeHit)
        |=> irqStatus_q[BIT_SUMMARY_PIN];
    endproperty
    a_summary: assert property (p_summary) // R12
        else $error("summary bit not set");

    // Summary mask, set bit enables
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irqMask_q <= 8'h00;
        end else if (regWrite && regAddr == OFS_IRQ_MASK) begin
            irqMask_q <= regWrData;
        end
    end

    // Level interrupt from a flop
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStatus_q & irqMask_q);
        end
    end

    // Read mux; the pin level is sampled in the strobe cycle
    always_comb begin
        rdData_d = 8'h00;
        for (int i = 0; i < PINS; i++) begin
            if (regAddr == OFS_PIN_BASE + 5'(i)) begin
                rdData_d = pinCtrl_q[i];
                // Output mode still samples the pad; software ignores it
                rdData_d[BIT_DIN] = pinIn[i]; // R5 R6
            end
        end
        for (int i = 0; i < SWS; i++) begin
            if (regAddr == OFS_SW_BASE + 5'(i)) begin
                rdData_d = swCtrl_q[i];
            end
        end
        if (regAddr == OFS_PIN_FLAGS) begin
            rdData_d = 8'(pinFlags_q);
        end
        if (regAddr == OFS_IRQ_STATUS) begin
            rdData_d = irqStatus_q;
        end
        if (regAddr == OFS_IRQ_MASK) begin
            rdData_d = irqMask_q;
        end
    end

    // Read data valid only the cycle after the strobe
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            regRdData <= 8'h00;
        end else if (regRead) begin
            regRdData <= rdData_d;
        end else begin
            regRdData <= 8'h00;
        end
    end

endmodule

/* gpb_pad_model.sv */
`timescale 1ns/100ps
module gpb_pad_model
    import gpb_pkg::*;
(
    input wire logic [PIN_COUNT-1:0] pinOut,
    input wire logic [PIN_COUNT-1:0] pinOe_n,
    input wire logic [PIN_COUNT-1:0] extEn,
    input wire logic [PIN_COUNT-1:0] extLvl,
    output logic [PIN_COUNT-1:0] pinIn
);
    // Pad wire: device driver wins, then platform source, else board pull-up
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (!pinOe_n[i]) begin
                pinIn[i] = pinOut[i];
            end else if (extEn[i]) begin
                pinIn[i] = extLvl[i];
            end else begin
                pinIn[i] = 1'b1;
            end
        end
    end
endmodule

/* gpio_pin_control_bank_tb.sv */
`timescale 1ns/100ps
module gpio_pin_control_bank_tb import gpb_pkg::*; ;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [4:0] regAddr = 5'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [7:0] regRdData;
    logic [7:0] pinIn;
    logic [7:0] pinOut;
    logic [7:0] pinOe_n;
    logic [3:0] swOut;
    logic [3:0] swOe_n;
    logic irq;
    logic [7:0] extEn = 8'hfe; // Pin 0 left to the device
    logic [7:0] extLvl = 8'ha5;
    int fails = 0;
    int num_checks = 0;
    // Short millisecond so every filter length fits in the run
    localparam int TICK_SIM = 10;
    // Drive table for pin 0: control value and expected {oe_n, wire}
    logic [7:0] ctlTab [6] = '{8'h0a, 8'h09, 8'h01, 8'h08, 8'h00, 8'h0b};
    logic [1:0] padTab [6] = '{2'h3, 2'h1, 2'h0, 2'h3, 2'h0, 2'h3};

    always #20 core_clk = ~core_clk;

    gpb_pin_bank #(.TICK_LEN(TICK_SIM)) gpb_pin_bank_inst (.core_clk(core_clk),
        .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .pinIn(pinIn), .pinOut(pinOut), .pinOe_n(pinOe_n),
        .swOut(swOut), .swOe_n(swOe_n), .irq(irq));
    gpb_pad_model gpb_pad_model_inst (.pinOut(pinOut), .pinOe_n(pinOe_n), .extEn(extEn),
        .extLvl(extLvl), .pinIn(pinIn));

    // Idle cycles, ending just past the edge so outputs have settled
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // One-cycle write strobe
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask
    // One-cycle read strobe; data taken in the following cycle only
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1;
        d = regRdData;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Read a register, keep only the bits of interest
    task automatic chkRd(input logic [4:0] a, input logic [7:0] msk, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(d & msk, exp);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Watchdog at 10000 cycles, about ten times the cycles the tests need
    initial begin
        #400000;
        fails++;
        report_and_stop();
    end

    initial begin
        logic [1:0] e;
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        idle(1);
        chk(pinOe_n, 8'hff);
        chk({swOe_n, swOut}, 8'h00);
        for (int i = 1; i < 8; i++) begin
            chkRd(5'(i), 8'hff, PIN_CTRL_RESET | {5'h0, extLvl[i], 2'h0});
        end
        for (int i = 0; i < 4; i++) begin
            chkRd(OFS_SW_BASE + 5'(i), 8'hff, SW_CTRL_RESET);
        end
        chkRd(5'h1f, 8'hff, 8'h00);
        $display("test reset done");
        // Pin 0 through every driver and direction mix, then switch 0; bit 2 masked out of every pin 0 read check
        for (int i = 0; i < 6; i++) begin
            wr(OFS_PIN_BASE, ctlTab[i]);
            idle(2);
            chk({6'h0, pinOe_n[0], pinIn[0]}, {6'h0, padTab[i]});
            chkRd(OFS_PIN_BASE, 8'hfb, ctlTab[i]);
        end
        wr(OFS_SW_BASE, 8'hff);
        idle(2);
        chk({6'h0, swOe_n[0], swOut[0]}, 8'h01);
        chkRd(OFS_SW_BASE, 8'hff, 8'hff & SW_WRITE_MASK);
        $display("test drive done");
        // Every edge selector on pin 1, rising then falling
        wr(OFS_IRQ_MASK, 8'h10);
        for (int k = 0; k < 4; k++) begin
            e = 2'(k);
            wr(5'h01, {2'h0, e, 4'h2});
            idle(4);
            wr(OFS_PIN_FLAGS, 8'hff);
            wr(OFS_IRQ_STATUS, 8'hff);
            extLvl[1] <= 1'b1;
            idle(6);
            chkRd(OFS_PIN_FLAGS, 8'hff, {6'h0, e[1], 1'b0});
            chkRd(OFS_IRQ_STATUS, 8'hff, {3'h0, e[1], 4'h0});
            chk({7'h0, irq}, {7'h0, e[1]});
            wr(OFS_PIN_FLAGS, 8'hff);
            wr(OFS_IRQ_STATUS, 8'hff);
            extLvl[1] <= 1'b0;
            idle(6);
            chkRd(OFS_PIN_FLAGS, 8'hff, {6'h0, e[0], 1'b0});
        end
        wr(OFS_IRQ_MASK, 8'h00);
        idle(2);
        chk({7'h0, irq}, 8'h00);
        wr(OFS_IRQ_MASK, 8'h10);
        idle(2);
        chk({7'h0, irq}, 8'h01);
        wr(OFS_IRQ_STATUS, 8'h10);
        idle(2);
        chk({7'h0, irq}, 8'h00);
        $display("test edges done");
        // A short glitch must not pass a 10 ms filter
        wr(5'h01, 8'h72);
        idle(4);
        wr(OFS_PIN_FLAGS, 8'hff);
        extLvl[1] <= 1'b1;
        idle(50);
        extLvl[1] <= 1'b0;
        idle(6);
        chkRd(OFS_PIN_FLAGS, 8'hff, 8'h00);
        // Each filter length: quiet just short of it, flagged just past it
        for (int s = 1; s < 4; s++) begin
            wr(5'h01, {2'(s), 6'h32});
            wr(OFS_PIN_FLAGS, 8'hff);
            extLvl[1] <= ~extLvl[1];
            idle(s * DBNC_STEP_MS * TICK_SIM - 2 * TICK_SIM);
            chkRd(OFS_PIN_FLAGS, 8'hff, 8'h00);
            idle(3 * TICK_SIM);
            chkRd(OFS_PIN_FLAGS, 8'hff, 8'h02);
        end
        $display("test debounce done");
        report_and_stop();
    end
endmodule
